// ### verilog/imtc_pkg.sv
// Constants, types and register map of the two-wire master control block
package imtc_pkg;
  // APB byte offsets
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DATA   = 12'h008;
  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic done;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic interface_enable;
    logic rsv;
    logic interrupt_enable;
  } imtc_ctrl_s;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] STATUS_MASK = 8'hf8;
  // Status codes, prescaler bits zero
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RSTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK  = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DT_ACK  = 8'h28;
  localparam logic [7:0] ST_DT_NACK = 8'h30;
  localparam logic [7:0] ST_ARB     = 8'h38;
  localparam logic [7:0] ST_AR_ACK  = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK  = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  localparam logic [7:0] ST_NONE    = 8'hf8;
  // Bit timing: link period split in four quarters
  localparam int CLK_NS  = 5;
  localparam int LINK_NS = 125;
  localparam int QTR_DEF = (LINK_NS / (4 * CLK_NS) < 1) ? 1 : LINK_NS / (4 * CLK_NS);
  localparam logic [1:0] PH_DRIVE  = 2'h0;
  localparam logic [1:0] PH_RISE   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL   = 2'h3;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  // Engine states, one-hot
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_START = 6'h02,
    S_HOLD  = 6'h04,
    S_XFER  = 6'h08,
    S_ACK   = 6'h10,
    S_STOP  = 6'h20
  } imtc_state_e;
endpackage

// ### verilog/imtc_top.sv
// Two-wire master control engine with APB register access
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module imtc_top
  import imtc_pkg::*;
#(
  parameter int QTR_CYC = QTR_DEF,
  parameter int CNT_W   = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  output var  logic        irq
);
  if (QTR_CYC < 1 || QTR_CYC >= (1 << CNT_W)) begin : g_chk
    $error("QTR_CYC out of range for CNT_W");
  end
  imtc_ctrl_s       ctrl;
  imtc_ctrl_s       next_ctrl;
  imtc_state_e      st;
  imtc_state_e      next_st;
  logic [7:0]       status;
  logic [7:0]       next_status;
  logic [7:0]       data;
  logic [7:0]       next_data;
  logic [7:0]       sh;
  logic [7:0]       next_sh;
  logic [1:0]       ph;
  logic [1:0]       next_ph;
  logic [2:0]       bitn;
  logic [2:0]       next_bitn;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [31:0]      next_rd;
  logic             scl_drv;
  logic             next_scl;
  logic             sda_drv;
  logic             next_sda;
  logic             own;
  logic             next_own;
  logic             mrx;
  logic             next_mrx;
  logic             adr;
  logic             next_adr;
  logic             nack;
  logic             next_nack;
  logic             busy;
  logic             next_busy;
  logic             scl_s1;
  logic             scl_s2;
  logic             sda_s1;
  logic             sda_s2;
  logic             sda_d;
  logic             wr;
  logic             mapped;
  logic             tick;
  logic             stall;
  logic             set_done;
  logic             rx;
  // Pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end
  // Open-drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_drv;
  assign sda_oe  = sda_drv;
  assign irq     = ctrl.done & ctrl.interrupt_enable;
  // Bus answers in the access phase, no wait states
  assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr      = psel & penable & pwrite & mapped;
  // A released clock held low by a slave stretches the high phases
  assign stall = ~scl_drv & ~scl_s2 & ph[1];
  assign tick  = (cnt == CNT_W'(QTR_CYC - 1)) & ~stall;
  assign rx    = mrx & ~adr;
  // Registers and bit engine; the bus watcher is the next block
  always_comb begin
    next_ctrl   = ctrl;
    next_status = status;
    next_data   = data;
    next_st     = st;
    next_ph     = ph;
    next_bitn   = bitn;
    next_sh     = sh;
    next_scl    = scl_drv;
    next_sda    = sda_drv;
    next_own    = own;
    next_mrx    = mrx;
    next_adr    = adr;
    next_nack   = nack;
    next_rd     = prdata;
    next_cnt    = cnt;
    set_done    = 1'b0;
    // Read data captured in setup, so it comes from a flop
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        OFF_CTRL:   next_rd = {24'h00_0000, ctrl};
        OFF_STATUS: next_rd = {24'h00_0000, status & STATUS_MASK};
        OFF_DATA:   next_rd = {24'h00_0000, data};
        default:    next_rd = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == OFF_CTRL) begin
      next_ctrl.ack_enable       = pwdata[6];
      next_ctrl.start_request    = pwdata[5];
      next_ctrl.stop_request     = pwdata[4];
      next_ctrl.interface_enable = pwdata[2];
      next_ctrl.interrupt_enable = pwdata[0];
      if (pwdata[7]) begin
        next_ctrl.done = 1'b0;
      end
    end
    if (wr && paddr == OFF_DATA) begin
      if (ctrl.done) begin
        next_data                 = pwdata[7:0];
        next_ctrl.write_collision = 1'b0;
      end else begin
        next_ctrl.write_collision = 1'b1;
      end
    end
    // Quarter-bit divider runs only in the START, XFER, ACK and STOP states
    if (st == S_IDLE || st == S_HOLD || tick) begin
      next_cnt = '0;
    end else if (!stall) begin
      next_cnt = cnt + CNT_W'(1);
    end
    if (tick) begin
      next_ph = ph + 2'h1;
    end
    unique case (st)
      S_IDLE: begin
        next_scl = 1'b0;
        next_sda = 1'b0;
        next_own = 1'b0;
        next_ph  = PH_DRIVE;
        // Wait for a free bus before taking it
        if (ctrl.interface_enable & ctrl.start_request & ~ctrl.done & ~busy) begin
          next_st = S_START;
        end
      end
      S_START: begin
        if (tick) begin
          unique case (ph)
            PH_DRIVE:  next_sda = 1'b0;
            PH_RISE:   next_scl = 1'b0;
            PH_SAMPLE: next_sda = 1'b1;
            PH_FALL: begin
              next_scl    = 1'b1;
              set_done    = 1'b1;
              next_status = own ? ST_RSTART : ST_START;
              next_own    = 1'b1;
              next_st     = S_HOLD;
            end
          endcase
        end
      end
      S_HOLD: begin
        next_ph = PH_DRIVE;
        // Clock stays low while the flag is up, except after lost arbitration, which released it
        if (!ctrl.done) begin
          if (!own) begin
            next_st = S_IDLE;
          end else if (ctrl.stop_request) begin
            next_st = S_STOP;
          end else if (ctrl.start_request) begin
            next_st = S_START;
          end else if (status == ST_START || status == ST_RSTART) begin
            next_st   = S_XFER;
            next_sh   = data;
            next_adr  = 1'b1;
            next_mrx  = data[0];
            next_bitn = 3'h0;
          end else if (status == ST_AW_ACK || status == ST_AW_NACK ||
                       status == ST_DT_ACK || status == ST_DT_NACK ||
                       status == ST_AR_ACK || status == ST_DR_ACK) begin
            next_st   = S_XFER;
            next_sh   = data;
            next_adr  = 1'b0;
            next_bitn = 3'h0;
          end
        end
      end
      S_XFER: begin
        if (tick) begin
          unique case (ph)
            PH_DRIVE:  next_sda = rx ? 1'b0 : ~sh[7];
            PH_RISE:   next_scl = 1'b0;
            PH_SAMPLE: begin
              // Released a one but the line reads low: another master won
              if (!rx && !sda_drv && !sda_s2) begin
                next_sda    = 1'b0;
                next_scl    = 1'b0;
                next_own    = 1'b0;
                next_status = ST_ARB;
                set_done    = 1'b1;
                next_st     = S_HOLD;
              end else begin
                next_sh = {sh[6:0], sda_s2};
              end
            end
            PH_FALL: begin
              next_scl  = 1'b1;
              next_bitn = bitn + 3'h1;
              if (bitn == LAST_BIT) begin
                next_st = S_ACK;
              end
            end
          endcase
        end
      end
      S_ACK: begin
        if (tick) begin
          unique case (ph)
            PH_DRIVE:  next_sda = rx & ctrl.ack_enable;
            PH_RISE:   next_scl = 1'b0;
            PH_SAMPLE: next_nack = sda_s2;
            PH_FALL: begin
              next_scl = 1'b1;
              next_sda = 1'b0;
              set_done = 1'b1;
              next_st  = S_HOLD;
              if (rx) begin
                next_data   = sh;
                next_status = ctrl.ack_enable ? ST_DR_ACK : ST_DR_NACK;
              end else if (adr && mrx) begin
                next_status = nack ? ST_AR_NACK : ST_AR_ACK;
              end else if (adr) begin
                next_status = nack ? ST_AW_NACK : ST_AW_ACK;
              end else begin
                next_status = nack ? ST_DT_NACK : ST_DT_ACK;
              end
            end
          endcase
        end
      end
      S_STOP: begin
        if (tick) begin
          unique case (ph)
            PH_DRIVE:  next_sda = 1'b1;
            PH_RISE:   next_scl = 1'b0;
            PH_SAMPLE: next_sda = 1'b0;
            PH_FALL: begin
              next_ctrl.stop_request = 1'b0;
              next_own = 1'b0;
              next_st  = S_IDLE;
            end
          endcase
        end
      end
    endcase
    // Enable low drops the bus at once
    if (!ctrl.interface_enable) begin
      next_st  = S_IDLE;
      next_scl = 1'b0;
      next_sda = 1'b0;
      next_own = 1'b0;
    end
    // Hardware set wins over a software clear
    if (set_done) begin
      next_ctrl.done = 1'b1;
    end
  end
  // START and STOP seen on the wires track bus occupancy
  always_comb begin
    next_busy = busy;
    if (scl_s2 & sda_d & ~sda_s2) begin
      next_busy = 1'b1;
    end else if (scl_s2 & ~sda_d & sda_s2) begin
      next_busy = 1'b0;
    end
  end
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= CTRL_RST;
      status  <= ST_NONE;
      data    <= 8'h00;
      st      <= S_IDLE;
      ph      <= PH_DRIVE;
      bitn    <= 3'h0;
      sh      <= 8'h00;
      cnt     <= '0;
      prdata  <= 32'h0000_0000;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      own     <= 1'b0;
      mrx     <= 1'b0;
      adr     <= 1'b0;
      nack    <= 1'b0;
      busy    <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      status  <= next_status;
      data    <= next_data;
      st      <= next_st;
      ph      <= next_ph;
      bitn    <= next_bitn;
      sh      <= next_sh;
      cnt     <= next_cnt;
      prdata  <= next_rd;
      scl_drv <= next_scl;
      sda_drv <= next_sda;
      own     <= next_own;
      mrx     <= next_mrx;
      adr     <= next_adr;
      nack    <= next_nack;
      busy    <= next_busy;
    end
  end
endmodule
`default_nettype wire

// ### verification/imtc_slave.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module imtc_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  output var  logic       sda_oe,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_tog
);
  int         cnt;
  logic [7:0] sh;
  logic       act;
  initial begin
    sda_oe = 1'b0;
    rx_tog = 1'b0;
    act = 1'b0;
    cnt = 0;
  end
  // START and STOP: data line moves while clock is high
  always @(sda) begin
    if (scl === 1'b1) begin
      act = !sda;
      cnt = -1;
    end
  end
  // Bytes arrive MSB first, sampled on the rising clock
  always @(posedge scl) begin
    if (act && cnt < 8)
      sh = {sh[6:0], sda};
  end
  // Ack slot: pull low to ack, leave to pull-up for nack
  always @(negedge scl) begin
    if (act) begin
      cnt = cnt + 1;
      if (cnt == 8) begin
        rx_byte = sh;
        rx_tog = !rx_tog;
        sda_oe = !nack;
      end else if (cnt == 9) begin
        sda_oe = 1'b0;
        cnt = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/imtc_top_chk.sv
// Port-level properties of the two-wire master block
`timescale 1ns/10ps
`default_nettype none
module imtc_chk
  import imtc_pkg::*;
#(
  parameter int QTR_CYC = QTR_DEF,
  parameter int CNT_W   = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_c;
  // Control write taking effect this edge
  assign wr_c = psel && penable && pwrite && paddr == OFF_CTRL;
  // Lost arbitration releases the clock, so only a held clock must stay held
  chk_held_scl: assert property (irq && scl_oe && !wr_c |=> scl_oe)
    else $error("clock released while suspended");
  chk_sda_frozen: assert property (irq && !wr_c ##1 irq |-> $stable(sda_oe))
    else $error("data line moved while suspended");
  chk_done_stays: assert property (irq && !wr_c |=> irq)
    else $error("done dropped without a write");
  chk_done_clear: assert property (wr_c && pwdata[7] && irq |=> !irq)
    else $error("done not cleared by write");
  chk_irq_gated: assert property (wr_c && !pwdata[0] |=> !irq)
    else $error("irq with enable off");
  chk_enable_off: assert property (wr_c && !pwdata[2] |-> ##[1:4] !(scl_oe || sda_oe))
    else $error("bus driven while disabled");
  chk_status_low: assert property (psel && !penable && !pwrite && paddr == OFF_STATUS
    |=> prdata[2:0] == 3'h0)
    else $error("status low bits set");
  chk_open_drain: assert property (scl_oe || sda_oe |-> !scl_out && !sda_out)
    else $error("line driven high");
  cover property ($rose(irq));
  cover property (pslverr);
  cover property (wr_c && !pwdata[2]);
  cover property (irq && !scl_oe);
endmodule
bind imtc_top imtc_chk #(.QTR_CYC(QTR_CYC), .CNT_W(CNT_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// ### verification/tb_i2c_master_transmit_control.sv
// Self-checking bench for the two-wire master block
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_master_transmit_control;
  import imtc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        scl_out, scl_oe, sda_out, sda_oe, s_oe, nack, tog, q_on, arb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  sbyte, a;
  logic [16:0] e;
  logic [16:0] rq[$];
  logic [7:0]  bq[$];
  int          bad_count, checked;
  wire logic   scl_w = !scl_oe;
  // A second master on the wires can pull the data line to win arbitration
  wire logic   sda_w = !(sda_oe || s_oe || arb);
  imtc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  imtc_slave u_slv (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_oe(s_oe),
    .rx_byte(sbyte), .rx_tog(tog));
  // Clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = !pclk;
  end
  task automatic cmp(input logic [32:0] g, input logic [32:0] x);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [7:0] m, input logic er,
                    input logic [7:0] x);
    rq.push_back({m, er, x & m});
    q_on = 1'b1;
    apb(1'b0, ad, 8'h00);
    q_on = 1'b0;
  endtask
  task automatic load(input logic [7:0] b);
    bq.push_back(b);
    apb(1'b1, OFF_DATA, b);
  endtask
  // Resume with a control value, wait for done, check status
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    int n;
    apb(1'b1, OFF_CTRL, c);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      final_report();
    end
    rd(OFF_STATUS, STATUS_MASK, 1'b0, st);
  endtask
  // Read results against the oldest note
  always @(posedge pclk) begin
    if (q_on && psel && penable && pready && !pwrite && rq.size() > 0) begin
      e = rq.pop_front();
      cmp({pslverr, prdata[31:8], prdata[7:0] & e[16:9]}, {e[8], 24'h00_0000, e[7:0]});
    end
  end
  // Bytes seen by the slave; an unexpected byte never matches
  always @(tog) begin
    if (presetn === 1'b1)
      cmp({25'h000_0000, sbyte}, {25'h000_0000, bq.size() > 0 ? bq.pop_front() : ~sbyte});
  end
  initial begin
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    nack = 1'b0;
    arb = 1'b0;
    q_on = 1'b0;
    bad_count = 0;
    checked = 0;
    void'($urandom(10));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL, 8'hff, 1'b0, CTRL_RST);
    rd(OFF_STATUS, 8'hff, 1'b0, ST_NONE);
    rd(12'h00c, 8'hff, 1'b1, 8'h00);
    apb(1'b1, OFF_DATA, 8'h5a);
    rd(OFF_CTRL, 8'h08, 1'b0, 8'h08);
    $display("test registers done");
    step(8'ha5, ST_START);
    a = {7'($urandom % 120 + 8), 1'b0};
    load(a);
    rd(OFF_CTRL, 8'h08, 1'b0, 8'h00);
    step(8'h85, ST_AW_ACK);
    step(8'hb5, ST_START);
    load(a);
    step(8'h85, ST_AW_ACK);
    load(8'($urandom));
    step(8'h85, ST_DT_ACK);
    nack <= 1'b1;
    load(8'($urandom));
    step(8'h85, ST_DT_NACK);
    apb(1'b1, OFF_CTRL, 8'h95);
    n = 0;
    do begin
      apb(1'b0, OFF_CTRL, 8'h00);
      n++;
    end while (r[4] !== 1'b0 && n < 500);
    // Stop bit never cleared: the wait ran out
    if (r[4] !== 1'b0) begin
      bad_count++;
      final_report();
    end
    rd(OFF_CTRL, 8'h10, 1'b0, 8'h00);
    step(8'ha5, ST_START);
    // Another master holds the data line low while a one is released
    arb <= 1'b1;
    apb(1'b1, OFF_DATA, 8'hff);
    step(8'h85, ST_ARB);
    // Its release with the clock high is a STOP, so the bus turns free
    arb <= 1'b0;
    step(8'ha5, ST_START);
    $display("test arbitration done");
    load(a);
    step(8'h85, ST_AW_NACK);
    nack <= 1'b0;
    step(8'ha5, ST_RSTART);
    load(a | 8'h01);
    step(8'h85, ST_AR_ACK);
    apb(1'b1, OFF_CTRL, 8'h00);
    repeat (4) @(posedge pclk);
    cmp({31'h0000_0000, scl_oe, sda_oe}, 33'h0_0000_0000);
    $display("test bus sequence done");
    final_report();
  end
endmodule
`default_nettype wire
